// ---- hw/cdc_cfg_cfg.svh ----
/*
  constants of the configuration register slice: offsets, field positions,
  reset values and counts. assumes inclusion by bare name, definitions only.
*/
`ifndef CDC_CFG_CFG_SVH
`define CDC_CFG_CFG_SVH

`define OFS_PORT_DIRECTION_PULLUP       8'h21
`define OFS_BANDGAP_POWER_ON_CONVERSION_CONTROL   8'h22
`define OFS_GAIN_CORRECTION_FACTOR      8'h23
`define OFS_UNUSED_A                    8'h24
`define OFS_UNUSED_B                    8'h25
`define OFS_BANDGAP_TIME                8'h26
`define OFS_PULSE_SOURCE_SELECT         8'h27
`define OFS_CAP_RATIO_SELECT            8'h28
`define OFS_RES_RATIO_SELECT            8'h29
`define OFS_ALARM_RESULT_FILTER_CONTROL 8'h2a
`define OFS_EVENT_STATUS                8'h2b
`define OFS_EVENT_MASK                  8'h2c
`define OFS_RESULT_PENDING              8'h2d

`define POS_READ_END_TRIGGER      7
`define POS_PROCESSOR_TRIGGER     6
`define POS_PERMANENT_ON          5
`define POS_POWER_ON_CONVERSION   4
`define POS_ALARM_B_SOURCE        7
`define POS_ALARM_B_POLARITY      6
`define POS_ALARM_A_SOURCE        5
`define POS_ALARM_A_POLARITY      4
`define POS_HOLD_UNTIL_READ       3
`define POS_INTERNAL_SPEED        2
`define POS_RES_MEDIAN            1
`define POS_CAP_MEDIAN            0

`define POS_EV_REFRESH            0
`define POS_EV_POWER_ON_CONVERSION          1
`define POS_EV_RESULT_HELD        2

`define RST_PORT_DIRECTION_PULLUP       8'hf0
`define RST_BANDGAP_POWER_ON_CONVERSION_CONTROL   8'h07
`define RST_GAIN_CORRECTION_FACTOR      8'h40
`define RST_ZERO                        8'h00

`define NUM_RESULT_SLOTS          8
`define NUM_GP_PORTS              4

`endif

// ---- hw/cdc_cfg_pkg.sv ----
/*
  types shared by the configuration register slice.
  assumes nothing of its surroundings.
*/
package cdc_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] slot_t;
  typedef enum logic [2:0] {
    AS_WAIT = 3'b001,
    AS_FIRE = 3'b010,
    AS_DONE = 3'b100
  } power_on_conversion_e;
endpackage

// ---- hw/cdc_config_regs_gpio_bandgap_pulse.sv ----
/*
  configuration register slice 0x21..0x2d of a capacitance converter:
  port direction and pull-up, bandgap refresh control, power_on_conversion, gain
  correction, pulse sources, ratio selects, alarms, result hold, median.
  assumes a plain register port on clock, processor and converter strobes
  on the same clock, and gp port pins arriving asynchronously.
*/
`timescale 1ns/100ps
`include "cdc_cfg_cfg.svh"
module cdc_config_regs_gpio_bandgap_pulse (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  output logic             irq,
  input  wire logic [3:0]  gp_port_in,
  output logic      [3:0]  gp_port_out,
  output logic      [3:0]  gp_port_oe,
  output logic      [3:0]  gp_port_pullup,
  input  wire logic [3:0]  gp_data_out,
  input  wire logic        alarm_z_a,
  input  wire logic        alarm_theta_a,
  input  wire logic        alarm_z_b,
  input  wire logic        alarm_theta_b,
  output logic      [3:0]  gp_port_level,
  input  wire logic        result_read_end,
  input  wire logic        processor_bg_bit,
  output logic             bandgap_refresh,
  output logic             bandgap_enable,
  output logic             conversion_start,
  output logic      [8:0]  gain_factor_q8,
  input  wire logic        result_valid,
  input  wire logic [2:0]  result_slot,
  input  wire logic [31:0] result_data,
  input  wire logic        result_slot_read,
  input  wire logic [2:0]  result_read_slot,
  output logic             result_accept,
  output logic      [31:0] result_slot_data [`NUM_RESULT_SLOTS],
  output logic      [31:0] pulse_if0_value,
  output logic      [31:0] pulse_if1_value,
  output logic      [7:0]  cap_ratio_sel,
  output logic      [7:0]  res_ratio_sel,
  output logic      [1:0]  median_enable,
  output logic      [7:0]  reference_timing_field
);
  cdc_cfg_pkg::byte_t       port_direction_pullup;
  cdc_cfg_pkg::byte_t       bandgap_power_on_conversion_control;
  cdc_cfg_pkg::byte_t       gain_correction_factor;
  cdc_cfg_pkg::byte_t       bandgap_time;
  cdc_cfg_pkg::byte_t       pulse_source_select;
  cdc_cfg_pkg::byte_t       cap_ratio_select;
  cdc_cfg_pkg::byte_t       res_ratio_select;
  cdc_cfg_pkg::byte_t       alarm_result_filter_control;
  cdc_cfg_pkg::byte_t       event_status;
  cdc_cfg_pkg::byte_t       event_mask;
  logic [7:0]               slot_pending;
  logic [3:0]               port_sync;
  logic                     processor_bg_prev;
  cdc_cfg_pkg::power_on_conversion_e  power_on_conversion_state;
  cdc_cfg_pkg::power_on_conversion_e  next_power_on_conversion_state;
  logic                     wr_hit_status;
  logic                     ev_refresh;
  logic                     ev_power_on_conversion;
  logic                     ev_result_held;
  logic [3:0]               port_direction_bits;
  logic [3:0]               port_pullup_bits;
  logic                     read_end_refresh_trigger;
  logic                     processor_refresh_trigger;
  logic                     reference_permanent_on;
  logic                     power_on_conversion;
  logic                     hold_until_read;
  logic                     alarm_a_source;
  logic                     alarm_b_source;
  logic                     alarm_a_polarity;
  logic                     alarm_b_polarity;
  logic                     result_blocked;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [31:0] slot_pick(input logic [3:0] code,
                                            input logic [31:0] slots [`NUM_RESULT_SLOTS]);
    slot_pick = (code[3] == 1'b0) ? slots[code[2:0]] : 32'h0000_0000;
  endfunction

  // field views
  assign port_direction_bits       = port_direction_pullup[7:4];
  assign port_pullup_bits          = port_direction_pullup[3:0];
  assign read_end_refresh_trigger  = bandgap_power_on_conversion_control[`POS_READ_END_TRIGGER];
  assign processor_refresh_trigger = bandgap_power_on_conversion_control[`POS_PROCESSOR_TRIGGER];
  assign reference_permanent_on    = bandgap_power_on_conversion_control[`POS_PERMANENT_ON];
  assign power_on_conversion       = bandgap_power_on_conversion_control[`POS_POWER_ON_CONVERSION];
  assign hold_until_read           = alarm_result_filter_control[`POS_HOLD_UNTIL_READ];
  assign alarm_a_source            = alarm_result_filter_control[`POS_ALARM_A_SOURCE];
  assign alarm_b_source            = alarm_result_filter_control[`POS_ALARM_B_SOURCE];
  assign alarm_a_polarity          = alarm_result_filter_control[`POS_ALARM_A_POLARITY];
  assign alarm_b_polarity          = alarm_result_filter_control[`POS_ALARM_B_POLARITY];

  // port direction and pull-up nibbles
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_direction_pullup <= `RST_PORT_DIRECTION_PULLUP;
    end else if (reg_write && hit(reg_addr, `OFS_PORT_DIRECTION_PULLUP)) begin
      port_direction_pullup <= reg_wdata;
    end
  end

  // bandgap triggers, power_on_conversion and bandgap timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bandgap_power_on_conversion_control <= `RST_BANDGAP_POWER_ON_CONVERSION_CONTROL;
      bandgap_time              <= `RST_ZERO;
    end else if (reg_write) begin
      if (hit(reg_addr, `OFS_BANDGAP_POWER_ON_CONVERSION_CONTROL))
        bandgap_power_on_conversion_control <= reg_wdata;
      if (hit(reg_addr, `OFS_BANDGAP_TIME))
        bandgap_time <= reg_wdata;
    end
  end

  // gain correction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_correction_factor <= `RST_GAIN_CORRECTION_FACTOR;
    end else if (reg_write && hit(reg_addr, `OFS_GAIN_CORRECTION_FACTOR)) begin
      gain_correction_factor <= reg_wdata;
    end
  end

  // pulse interface sources
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_source_select <= `RST_ZERO;
    end else if (reg_write && hit(reg_addr, `OFS_PULSE_SOURCE_SELECT)) begin
      pulse_source_select <= reg_wdata;
    end
  end

  // ratio selects for the linearization firmware
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_ratio_select <= `RST_ZERO;
      res_ratio_select <= `RST_ZERO;
    end else if (reg_write) begin
      if (hit(reg_addr, `OFS_CAP_RATIO_SELECT))
        cap_ratio_select <= reg_wdata;
      if (hit(reg_addr, `OFS_RES_RATIO_SELECT))
        res_ratio_select <= reg_wdata;
    end
  end

  // alarm, result hold and median controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_result_filter_control <= `RST_ZERO;
    end else if (reg_write && hit(reg_addr, `OFS_ALARM_RESULT_FILTER_CONTROL)) begin
      alarm_result_filter_control <= reg_wdata;
    end
  end

  // event mask; unused, unmapped and read-only offsets ignore writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_mask <= `RST_ZERO;
    end else if (reg_write && hit(reg_addr, `OFS_EVENT_MASK)) begin
      event_mask <= reg_wdata;
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_PORT_DIRECTION_PULLUP:       reg_rdata <= port_direction_pullup;
        `OFS_BANDGAP_POWER_ON_CONVERSION_CONTROL:   reg_rdata <= bandgap_power_on_conversion_control;
        `OFS_GAIN_CORRECTION_FACTOR:      reg_rdata <= gain_correction_factor;
        `OFS_BANDGAP_TIME:                reg_rdata <= bandgap_time;
        `OFS_PULSE_SOURCE_SELECT:         reg_rdata <= pulse_source_select;
        `OFS_CAP_RATIO_SELECT:            reg_rdata <= cap_ratio_select;
        `OFS_RES_RATIO_SELECT:            reg_rdata <= res_ratio_select;
        `OFS_ALARM_RESULT_FILTER_CONTROL: reg_rdata <= alarm_result_filter_control;
        `OFS_EVENT_STATUS:                reg_rdata <= event_status;
        `OFS_EVENT_MASK:                  reg_rdata <= event_mask;
        `OFS_RESULT_PENDING:              reg_rdata <= slot_pending;
        default:                          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // gp port pins; direction 0 = output, 1 = input
  sync_two_ff #(.WIDTH(`NUM_GP_PORTS)) u_port_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (gp_port_in),
    .sync_out (port_sync)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gp_port_out    <= 4'h0;
      gp_port_oe     <= 4'h0;
      gp_port_pullup <= 4'h0;
      gp_port_level  <= 4'h0;
    end else begin
      gp_port_oe     <= ~port_direction_bits;
      gp_port_pullup <= port_pullup_bits;
      gp_port_level  <= port_sync;
      // alarms on ports 0 and 1, active high, polarity bit inverts
      gp_port_out[0] <= (alarm_a_source ? alarm_theta_a : alarm_z_a) ^ alarm_a_polarity;
      gp_port_out[1] <= (alarm_b_source ? alarm_theta_b : alarm_z_b) ^ alarm_b_polarity;
      gp_port_out[3:2] <= gp_data_out[3:2];
    end
  end

  // bandgap refresh and enable
  assign ev_refresh = (read_end_refresh_trigger && result_read_end) ||
                      (processor_refresh_trigger && processor_bg_bit && !processor_bg_prev);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      processor_bg_prev <= 1'b0;
      bandgap_refresh   <= 1'b0;
      bandgap_enable    <= 1'b0;
    end else begin
      processor_bg_prev <= processor_bg_bit;
      bandgap_refresh   <= ev_refresh;
      bandgap_enable    <= reference_permanent_on | ev_refresh;
    end
  end

  // one conversion after power-on, at the first power_on_conversion enable;
  // configuration often lands after reset release, so wait for it
  always_comb begin
    next_power_on_conversion_state = power_on_conversion_state;
    case (power_on_conversion_state)
      cdc_cfg_pkg::AS_WAIT: next_power_on_conversion_state = power_on_conversion ? cdc_cfg_pkg::AS_FIRE
                                                                       : cdc_cfg_pkg::AS_WAIT;
      cdc_cfg_pkg::AS_FIRE: next_power_on_conversion_state = cdc_cfg_pkg::AS_DONE;
      cdc_cfg_pkg::AS_DONE: next_power_on_conversion_state = cdc_cfg_pkg::AS_DONE;
      default:              next_power_on_conversion_state = cdc_cfg_pkg::AS_DONE;
    endcase
  end

  assign ev_power_on_conversion = (power_on_conversion_state == cdc_cfg_pkg::AS_FIRE);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_on_conversion_state  <= cdc_cfg_pkg::AS_WAIT;
      conversion_start <= 1'b0;
    end else begin
      power_on_conversion_state  <= next_power_on_conversion_state;
      conversion_start <= ev_power_on_conversion;
    end
  end

  // gain factor in q8: 0 gives 0, n gives 256 + n
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_factor_q8 <= 9'h000;
    end else begin
      gain_factor_q8 <= (gain_correction_factor == 8'h00) ? 9'h000
                      : {1'b1, gain_correction_factor};
    end
  end

  // result slots with optional hold until read
  assign result_blocked = hold_until_read && slot_pending[result_slot];
  assign result_accept  = !result_blocked;
  assign ev_result_held = result_valid && result_blocked;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slot_pending <= 8'h00;
      for (int i = 0; i < `NUM_RESULT_SLOTS; i++) begin
        result_slot_data[i] <= 32'h0000_0000;
      end
    end else begin
      if (result_slot_read)
        slot_pending[result_read_slot] <= 1'b0;
      if (result_valid && !result_blocked) begin
        result_slot_data[result_slot] <= result_data;
        slot_pending[result_slot]     <= 1'b1;
      end
    end
  end

  // pulse interface sources
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_if0_value <= 32'h0000_0000;
      pulse_if1_value <= 32'h0000_0000;
    end else begin
      pulse_if0_value <= slot_pick(pulse_source_select[3:0], result_slot_data);
      pulse_if1_value <= slot_pick(pulse_source_select[7:4], result_slot_data);
    end
  end

  // firmware-facing settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_ratio_sel          <= 8'h00;
      res_ratio_sel          <= 8'h00;
      median_enable          <= 2'b00;
      reference_timing_field <= 8'h00;
    end else begin
      cap_ratio_sel          <= cap_ratio_select;
      res_ratio_sel          <= res_ratio_select;
      median_enable          <= {alarm_result_filter_control[`POS_RES_MEDIAN],
                                 alarm_result_filter_control[`POS_CAP_MEDIAN]};
      reference_timing_field <= bandgap_time;
    end
  end

  // sticky events, cleared by reading status; a new event wins
  assign wr_hit_status = reg_read && hit(reg_addr, `OFS_EVENT_STATUS);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_status <= 8'h00;
    end else begin
      if (wr_hit_status)
        event_status <= 8'h00;
      if (ev_refresh)
        event_status[`POS_EV_REFRESH] <= 1'b1;
      if (ev_power_on_conversion)
        event_status[`POS_EV_POWER_ON_CONVERSION] <= 1'b1;
      if (ev_result_held)
        event_status[`POS_EV_RESULT_HELD] <= 1'b1;
    end
  end

  assign irq = |(event_status & event_mask);
endmodule // cdc_config_regs_gpio_bandgap_pulse

// ---- hw/sync_two_ff.sv ----
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes inputs are asynchronous levels; only stage two is read outside.
*/
`timescale 1ns/100ps
module sync_two_ff #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // sync_two_ff

// ---- tb/cdc_cfg_asserts.sv ----
/*
  checker for the configuration slice: ties outputs to a shadow of the
  register writes seen at the port. assumes it is bound to the slice top.
*/
`timescale 1ns/100ps
`include "cdc_cfg_cfg.svh"
module cdc_cfg_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        irq,
  input wire logic [3:0]  gp_port_out,
  input wire logic [3:0]  gp_port_oe,
  input wire logic [3:0]  gp_port_pullup,
  input wire logic        alarm_z_a,
  input wire logic        alarm_theta_a,
  input wire logic        alarm_z_b,
  input wire logic        alarm_theta_b,
  input wire logic        result_read_end,
  input wire logic        processor_bg_bit,
  input wire logic        bandgap_refresh,
  input wire logic        bandgap_enable,
  input wire logic        conversion_start,
  input wire logic [8:0]  gain_factor_q8,
  input wire logic        result_valid,
  input wire logic        result_accept,
  input wire logic [31:0] result_slot_data [`NUM_RESULT_SLOTS],
  input wire logic [31:0] pulse_if0_value,
  input wire logic [31:0] pulse_if1_value,
  input wire logic [7:0]  cap_ratio_sel,
  input wire logic [7:0]  res_ratio_sel,
  input wire logic [1:0]  median_enable
);
  logic [7:0] sh [33:42];
  logic [1:0] quiet;
  logic       prev_bg;
  wire logic  in_cfg = reg_addr >= 8'h21 && reg_addr <= 8'h2a;
  wire logic [7:0] exp_rd = in_cfg ? sh[reg_addr] : 8'h00;
  wire logic  trig = (sh[34][7] && result_read_end) || (sh[34][6] && processor_bg_bit && !prev_bg);
  wire logic [1:0] alarm_sel = {sh[42][7] ? alarm_theta_b : alarm_z_b, sh[42][5] ? alarm_theta_a : alarm_z_a};

  // shadow of writable fields; 0x24 and 0x25 stay zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 33; i <= 42; i++) sh[i] <= 8'h00;
      sh[33] <= 8'hf0;
      sh[34] <= 8'h07;
      sh[35] <= 8'h40;
    end else if (reg_write && in_cfg && reg_addr != 8'h24 && reg_addr != 8'h25) begin
      sh[reg_addr] <= reg_wdata;
    end
  end

  // cycles since the last write of any kind, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) quiet <= 2'h0;
    else if (reg_write || result_valid) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) prev_bg <= 1'b0;
    else prev_bg <= processor_bg_bit;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  cfg_readback_a: assert property (reg_read && in_cfg |=> reg_rdata == $past(exp_rd))
    else $error("config read data wrong");
  dir_pullup_a: assert property (quiet == 2'h3 |-> gp_port_oe == ~sh[33][7:4] && gp_port_pullup == sh[33][3:0])
    else $error("port direction or pull-up wrong");
  gain_map_a: assert property (quiet == 2'h3 |-> gain_factor_q8 == (sh[35] == 8'h00 ? 9'h000 : {1'b1, sh[35]}))
    else $error("gain factor wrong");
  ratio_copy_a: assert property (quiet == 2'h3 |-> cap_ratio_sel == sh[40] && res_ratio_sel == sh[41]
    && median_enable == sh[42][1:0]) else $error("ratio or median copy wrong");
  refresh_cause_a: assert property (trig |=> bandgap_refresh)
    else $error("refresh missing after trigger");
  refresh_only_a: assert property (bandgap_refresh |-> $past(trig))
    else $error("refresh without enabled trigger");
  permanent_on_a: assert property (quiet == 2'h3 && sh[34][5] |-> bandgap_enable)
    else $error("bandgap not permanently on");
  no_power_on_conversion_a: assert property (conversion_start |-> sh[34][4])
    else $error("conversion start without power_on_conversion");
  pulse_route_a: assert property (quiet == 2'h3 |-> pulse_if0_value == (sh[39][3] ? 32'h0 : result_slot_data[sh[39][2:0]])
    && pulse_if1_value == (sh[39][7] ? 32'h0 : result_slot_data[sh[39][6:4]])) else $error("pulse source wrong");
  alarm_route_a: assert property (quiet == 2'h3 |-> gp_port_out[1:0] == ($past(alarm_sel) ^ {sh[42][6], sh[42][4]}))
    else $error("alarm output wrong");
  accept_free_a: assert property (!sh[42][3] |-> result_accept)
    else $error("result refused without hold");

  refresh_c: cover property (trig ##1 bandgap_refresh);
  drop_c: cover property (result_valid && !result_accept);
  irq_c: cover property ($rose(irq));
  power_on_conversion_c: cover property (conversion_start);
endmodule // cdc_cfg_asserts

// ---- tb/tb_cdc_config_regs_gpio_bandgap_pulse.sv ----
/*
  self-checking bench for the configuration slice: register port tasks and
  scenario sequences. assumes the slice, its header and the checker.
*/
`timescale 1ns/100ps
`include "cdc_cfg_cfg.svh"
module tb_cdc_config_regs_gpio_bandgap_pulse;
  logic        clock, rst, reg_write, reg_read, irq, result_read_end, processor_bg_bit;
  logic        bandgap_refresh, bandgap_enable, conversion_start, result_valid, result_slot_read, result_accept;
  logic        alarm_z_a, alarm_theta_a, alarm_z_b, alarm_theta_b;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, cap_ratio_sel, res_ratio_sel, reference_timing_field;
  logic [3:0]  gp_port_in, gp_port_out, gp_port_oe, gp_port_pullup, gp_data_out, gp_port_level;
  logic [2:0]  result_slot, result_read_slot;
  logic [1:0]  median_enable;
  logic [8:0]  gain_factor_q8;
  logic [31:0] result_data, pulse_if0_value, pulse_if1_value;
  logic [31:0] result_slot_data [`NUM_RESULT_SLOTS];
  logic [7:0]  rst_val [10] = '{8'hf0, 8'h07, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  alarm_cfg [3] = '{8'h00, 8'ha0, 8'hb0};
  logic [1:0]  alarm_exp [3] = '{2'b01, 2'b10, 2'b11};
  int          err_count, n_checks, cycles;

  cdc_config_regs_gpio_bandgap_pulse cdc_config_regs_gpio_bandgap_pulse_inst (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .gp_port_in, .gp_port_out,
    .gp_port_oe, .gp_port_pullup, .gp_data_out, .alarm_z_a, .alarm_theta_a, .alarm_z_b, .alarm_theta_b,
    .gp_port_level, .result_read_end, .processor_bg_bit, .bandgap_refresh, .bandgap_enable, .conversion_start,
    .gain_factor_q8, .result_valid, .result_slot, .result_data, .result_slot_read, .result_read_slot,
    .result_accept, .result_slot_data, .pulse_if0_value, .pulse_if1_value, .cap_ratio_sel, .res_ratio_sel,
    .median_enable, .reference_timing_field
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check({24'h0, reg_rdata}, {24'h0, exp});
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  // one-cycle trigger: read end pulse or processor bit rise
  task automatic fire(input bit proc);
    @(posedge clock);
    if (proc) processor_bg_bit <= 1'b1;
    else result_read_end <= 1'b1;
    @(posedge clock);
    processor_bg_bit <= 1'b0;
    result_read_end <= 1'b0;
    #1;
  endtask

  task automatic res(input logic [2:0] s, input logic [31:0] d);
    @(posedge clock);
    result_slot <= s;
    result_data <= d;
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, reg_write, reg_read, result_read_end, processor_bg_bit, result_valid, result_slot_read} = 7'h40;
    {reg_addr, reg_wdata, result_slot, result_read_slot, result_data} = '0;
    {alarm_z_a, alarm_theta_a, alarm_z_b, alarm_theta_b} = 4'b1001;
    gp_port_in = 4'h9;
    gp_data_out = 4'hc;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rdc(8'h21 + 8'(i), rst_val[i]);
    rdc(8'h50, 8'h00);
    for (int i = 0; i < 10; i++) wr(8'h21 + 8'(i), 8'h5a ^ 8'(i));
    for (int i = 0; i < 10; i++) rdc(8'h21 + 8'(i), (i == 3 || i == 4) ? 8'h00 : 8'h5a ^ 8'(i));
    rdc(8'h2b, 8'h02);
    settle();
    check(gp_port_oe, 4'ha);
    check(gp_port_pullup, 4'ha);
    check(gain_factor_q8, 9'h158);
    check({cap_ratio_sel, res_ratio_sel}, 16'h5d52);
    check(median_enable, 2'h3);
    check(reference_timing_field, 8'h5f);
    check(gp_port_level, 4'h9);
    wr(8'h23, 8'h00);
    settle();
    check(gain_factor_q8, 9'h000);
    wr(8'h23, 8'hff);
    settle();
    check(gain_factor_q8, 9'h1ff);
    wr(8'h2c, 8'h00);
    wr(8'h22, 8'h87);
    fire(1'b0);
    check(bandgap_refresh, 1'b1);
    fire(1'b1);
    check(bandgap_refresh, 1'b0);
    settle();
    check(irq, 1'b0);
    wr(8'h2c, 8'h01);
    settle();
    check(irq, 1'b1);
    rdc(8'h2b, 8'h01);
    settle();
    check(irq, 1'b0);
    wr(8'h22, 8'h47);
    fire(1'b1);
    check(bandgap_refresh, 1'b1);
    fire(1'b0);
    check(bandgap_refresh, 1'b0);
    wr(8'h22, 8'h27);
    settle();
    check(bandgap_enable, 1'b1);
    check(conversion_start, 1'b0);
    rdc(8'h2b, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(8'h2a, alarm_cfg[i]);
      settle();
      check(gp_port_out, {2'b11, alarm_exp[i]});
    end
    res(3'h2, 32'hdead0002);
    res(3'h3, 32'hbeef0003);
    wr(8'h27, 8'h32);
    settle();
    check(pulse_if0_value, 32'hdead0002);
    check(pulse_if1_value, 32'hbeef0003);
    wr(8'h27, 8'h3a);
    settle();
    check(pulse_if0_value, 32'h0);
    check(pulse_if1_value, 32'hbeef0003);
    wr(8'h2a, 8'h08);
    res(3'h2, 32'h12345678);
    settle();
    check(result_slot_data[2], 32'hdead0002);
    rdc(8'h2d, 8'h0c);
    rdc(8'h2b, 8'h04);
    @(posedge clock);
    result_read_slot <= 3'h2;
    result_slot_read <= 1'b1;
    @(posedge clock);
    result_slot_read <= 1'b0;
    res(3'h2, 32'h12345678);
    settle();
    check(result_slot_data[2], 32'h12345678);
    tally_and_finish();
  end
endmodule // tb_cdc_config_regs_gpio_bandgap_pulse

bind cdc_config_regs_gpio_bandgap_pulse cdc_cfg_asserts cdc_cfg_asserts_inst (
  .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .gp_port_out, .gp_port_oe,
  .gp_port_pullup, .alarm_z_a, .alarm_theta_a, .alarm_z_b, .alarm_theta_b, .result_read_end, .processor_bg_bit,
  .bandgap_refresh, .bandgap_enable, .conversion_start, .gain_factor_q8, .result_valid, .result_accept,
  .result_slot_data, .pulse_if0_value, .pulse_if1_value, .cap_ratio_sel, .res_ratio_sel, .median_enable
);
